// file: design/rpmc_pkg.sv
// Constants and types for the reset and power mode controller
// Overview of operation
// - A high level on the reset pin starts an initial reset.
// - Reset pin highs of 0.4 ms or less are rejected as noise.
// - Initial reset ends when the reset pin returns low.
// - All selected key inputs high together start an initial reset.
// - Key reset fires only after the combination lasts the one-to-two second hold.
// - Missing low-speed oscillation holds the chip in reset mode.
// - Detected oscillation releases the reset so the core runs.
// - Quick start mode resets the whole system every 16 seconds.
// - Secondary cell at 1.0 V or above ends quick start, enters normal mode.
// - Without the solar option reset goes straight to normal mode.
// - A status bit shows whether quick start mode is active.
// - Mode changes are made by hardware alone.
// - Five reset sources are merged; the software source resets peripherals only.
// - Writing one resets peripherals; zero does nothing; the bit reads zero.
// - Oscillator regulator stays in start-up state until oscillation is detected.
// - Software switches the LCD supply and picks one of 16 levels.
package rpmc_pkg;
  // Clocks
  localparam int CLK_HZ = 20_000_000;
  localparam int LS_HZ = 32_768;
  // Noise filter limits in microseconds and their low-speed tick counts
  localparam int REJECT_US = 400;
  localparam int ACCEPT_US = 1500;
  localparam int REJECT_TICKS = (REJECT_US * LS_HZ) / 1_000_000;
  localparam int ACCEPT_TICKS = (ACCEPT_US * LS_HZ) / 1_000_000;
  // Accept point halfway between the two limits
  localparam int FILTER_TICKS = (REJECT_TICKS + ACCEPT_TICKS) / 2;
  // Key hold of one second, cyclic reset of 16 seconds, cell sample period
  localparam int KEY_HOLD_S = 1;
  localparam int CYCLIC_S = 16;
  localparam int KEY_HOLD_TICKS = KEY_HOLD_S * LS_HZ;
  localparam int CYCLIC_TICKS = CYCLIC_S * LS_HZ;
  localparam int SAMPLE_TICKS = LS_HZ / 2;
  // Oscillation lost after four missing low-speed periods
  localparam int OSC_LOST_PERIODS = 4;
  localparam int OSC_LOST_CYCLES = OSC_LOST_PERIODS * (CLK_HZ / LS_HZ);
  localparam int CNT_W = 20;
  localparam int OSC_W = 12;
  // Register offsets
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STAT_ADDR = 4'h4;
  // Control fields
  localparam int CTRL_SRST_BIT = 0;
  localparam int CTRL_LCD_EN_BIT = 1;
  localparam int CTRL_LVL_LSB = 4;
  localparam logic [3:0] LCD_LVL_RESET = 4'h0;
  // Status fields
  localparam int STAT_QUICK_BIT = 0;
  localparam int STAT_NORMAL_BIT = 1;
  localparam int STAT_OSC_BIT = 2;
  localparam int STAT_PIN_BIT = 3;
  localparam int STAT_KEY_BIT = 4;
  // Responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Operating modes
  typedef enum logic [1:0] {
    RPMC_RESET = 2'b00,
    RPMC_QUICK = 2'b01,
    RPMC_NORMAL = 2'b10
  } rpmc_mode_t;
endpackage

// file: design/rpmc_top.sv
// Reset merging, noise filters, operating mode sequencer and register slave
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rpmc_top #(
  parameter logic [3:0] KEY_SELECT = 4'b1111,
  parameter bit SOLAR_EN = 1'b1,
  parameter int KEY_HOLD_TICKS = rpmc_pkg::KEY_HOLD_TICKS,
  parameter int CYCLIC_TICKS = rpmc_pkg::CYCLIC_TICKS,
  parameter int SAMPLE_TICKS = rpmc_pkg::SAMPLE_TICKS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic reset_pin,
  input wire logic [3:0] key_inputs,
  input wire logic low_speed_oscillator,
  input wire logic cell_at_1v0,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic core_reset,
  output logic periph_reset,
  output logic quick_mode,
  output logic osc_reg_startup,
  output logic lcd_supply_en,
  output logic [3:0] lcd_level
);

  localparam int W = rpmc_pkg::CNT_W;
  // Counter step that sticks at the limit
  function automatic logic [W-1:0] sat_inc(input logic [W-1:0] v, input logic [W-1:0] lim);
    sat_inc = (v >= lim) ? lim : v + 1'b1;
  endfunction
  // Address match on word offset, upper bits must be zero
  function automatic logic addr_hit(input logic [31:0] a, input logic [3:0] off);
    addr_hit = (a[31:4] == 28'h000_0000) && (a[3:0] == off);
  endfunction
  // Low-speed edge detect and oscillation watchdog
  logic ls_prev_q, ls_prev_d, osc_ok_q, osc_ok_d, ls_tick;
  logic [rpmc_pkg::OSC_W-1:0] osc_cnt_q, osc_cnt_d;
  assign ls_tick = low_speed_oscillator & ~ls_prev_q;
  // Oscillation counts as lost after several missing periods
  always_comb begin
    ls_prev_d = low_speed_oscillator;
    osc_cnt_d = osc_cnt_q;
    osc_ok_d = osc_ok_q;
    if (ls_tick) begin
      osc_cnt_d = '0;
      osc_ok_d = 1'b1;
    end else if (osc_cnt_q == rpmc_pkg::OSC_W'(rpmc_pkg::OSC_LOST_CYCLES)) begin
      osc_ok_d = 1'b0;
    end else begin
      osc_cnt_d = osc_cnt_q + 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ls_prev_q <= 1'b0;
      osc_cnt_q <= '0;
      osc_ok_q <= 1'b0;
    end else begin
      ls_prev_q <= ls_prev_d;
      osc_cnt_q <= osc_cnt_d;
      osc_ok_q <= osc_ok_d;
    end
  end
  // Noise filters for the pin and the key combination
  logic key_all_high, pin_ok_q, pin_ok_d, key_ok_q, key_ok_d;
  logic [W-1:0] pin_cnt_q, pin_cnt_d, keyf_cnt_q, keyf_cnt_d, hold_cnt_q, hold_cnt_d;
  // An all-zero selection means the key reset is not fitted
  assign key_all_high = (KEY_SELECT != 4'h0) && ((key_inputs & KEY_SELECT) == KEY_SELECT);
  // Counters advance only on low-speed ticks, so a stopped oscillator blocks them
  always_comb begin
    pin_cnt_d = pin_cnt_q;
    keyf_cnt_d = keyf_cnt_q;
    hold_cnt_d = hold_cnt_q;
    if (!reset_pin) begin
      pin_cnt_d = '0;
    end else if (ls_tick) begin
      pin_cnt_d = sat_inc(pin_cnt_q, W'(rpmc_pkg::FILTER_TICKS));
    end
    if (!key_all_high) begin
      keyf_cnt_d = '0;
      hold_cnt_d = '0;
    end else if (ls_tick) begin
      keyf_cnt_d = sat_inc(keyf_cnt_q, W'(rpmc_pkg::FILTER_TICKS));
      if (keyf_cnt_q == W'(rpmc_pkg::FILTER_TICKS)) begin
        hold_cnt_d = sat_inc(hold_cnt_q, W'(KEY_HOLD_TICKS));
      end
    end
    // Release follows the pin falling at once
    pin_ok_d = reset_pin && (pin_cnt_q == W'(rpmc_pkg::FILTER_TICKS));
    key_ok_d = key_all_high && (hold_cnt_q == W'(KEY_HOLD_TICKS));
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_cnt_q <= '0;
      keyf_cnt_q <= '0;
      hold_cnt_q <= '0;
      pin_ok_q <= 1'b0;
      key_ok_q <= 1'b0;
    end else begin
      pin_cnt_q <= pin_cnt_d;
      keyf_cnt_q <= keyf_cnt_d;
      hold_cnt_q <= hold_cnt_d;
      pin_ok_q <= pin_ok_d;
      key_ok_q <= key_ok_d;
    end
  end
  // Operating mode sequencer
  rpmc_pkg::rpmc_mode_t mode_q, mode_d;
  logic [W-1:0] cyc_cnt_q, cyc_cnt_d, smp_cnt_q, smp_cnt_d;
  logic cyc_rst_q, cyc_rst_d, sys_rst_req;
  assign sys_rst_req = pin_ok_q | key_ok_q | ~osc_ok_q | cyc_rst_q;
  // Hardware steps modes on its own; software has no say
  always_comb begin
    mode_d = mode_q;
    cyc_cnt_d = cyc_cnt_q;
    smp_cnt_d = smp_cnt_q;
    cyc_rst_d = cyc_rst_q;
    case (mode_q)
      rpmc_pkg::RPMC_RESET: begin
        cyc_cnt_d = '0;
        smp_cnt_d = '0;
        // Cyclic reset lasts one low-speed period
        if (ls_tick) begin
          cyc_rst_d = 1'b0;
        end
        if (!sys_rst_req) begin
          mode_d = SOLAR_EN ? rpmc_pkg::RPMC_QUICK : rpmc_pkg::RPMC_NORMAL;
        end
      end
      rpmc_pkg::RPMC_QUICK: begin
        if (sys_rst_req) begin
          mode_d = rpmc_pkg::RPMC_RESET;
        end else if (ls_tick) begin
          cyc_cnt_d = cyc_cnt_q + 1'b1;
          smp_cnt_d = smp_cnt_q + 1'b1;
          if (smp_cnt_q == W'(SAMPLE_TICKS - 1)) begin
            smp_cnt_d = '0;
            if (cell_at_1v0) begin
              mode_d = rpmc_pkg::RPMC_NORMAL;
            end
          end
          if (mode_d == rpmc_pkg::RPMC_QUICK && cyc_cnt_q == W'(CYCLIC_TICKS - 1)) begin
            cyc_rst_d = 1'b1;
            mode_d = rpmc_pkg::RPMC_RESET;
          end
        end
      end
      rpmc_pkg::RPMC_NORMAL: begin
        // Cyclic reset is off in normal mode
        if (sys_rst_req) begin
          mode_d = rpmc_pkg::RPMC_RESET;
        end
      end
      default: begin
        mode_d = rpmc_pkg::RPMC_RESET;
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= rpmc_pkg::RPMC_RESET;
      cyc_cnt_q <= '0;
      smp_cnt_q <= '0;
      cyc_rst_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      cyc_cnt_q <= cyc_cnt_d;
      smp_cnt_q <= smp_cnt_d;
      cyc_rst_q <= cyc_rst_d;
    end
  end
  // Register slave state
  logic aw_held_q, aw_held_d, w_held_q, w_held_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [31:0] awaddr_q, awaddr_d, wdata_q, wdata_d, rdata_q, rdata_d, stat_word, ctrl_word;
  logic [3:0] wstrb_q, wstrb_d, lcd_lvl_q, lcd_lvl_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic lcd_en_q, lcd_en_d, srst_q, srst_d, core_rst_q, core_rst_d, per_rst_q, per_rst_d;
  logic quick_q, quick_d, reg_start_q, reg_start_d;
  // Soft reset bit always reads zero
  assign ctrl_word = {24'h00_0000, lcd_lvl_q, 2'b00, lcd_en_q, 1'b0};
  assign stat_word = {27'h000_0000, key_ok_q, pin_ok_q, osc_ok_q,
                      mode_q == rpmc_pkg::RPMC_NORMAL, mode_q == rpmc_pkg::RPMC_QUICK};
  // Write and read channels, plus control bits they steer
  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    lcd_en_d = lcd_en_q;
    lcd_lvl_d = lcd_lvl_q;
    srst_d = 1'b0;
    if (awvalid && awready) begin
      aw_held_d = 1'b1;
      awaddr_d = awaddr;
    end
    if (wvalid && wready) begin
      w_held_d = 1'b1;
      wdata_d = wdata;
      wstrb_d = wstrb;
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    // Commit once address and data are both in hand
    if (aw_held_q && w_held_q && !bvalid_q) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = rpmc_pkg::RESP_OKAY;
      if (addr_hit(awaddr_q, rpmc_pkg::CTRL_ADDR)) begin
        if (wstrb_q[0]) begin
          srst_d = wdata_q[rpmc_pkg::CTRL_SRST_BIT];
          lcd_en_d = wdata_q[rpmc_pkg::CTRL_LCD_EN_BIT];
          lcd_lvl_d = wdata_q[rpmc_pkg::CTRL_LVL_LSB +: 4];
        end
      end else if (!addr_hit(awaddr_q, rpmc_pkg::STAT_ADDR)) begin
        bresp_d = rpmc_pkg::RESP_SLVERR;
      end
    end
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rresp_d = rpmc_pkg::RESP_OKAY;
      if (addr_hit(araddr, rpmc_pkg::CTRL_ADDR)) begin
        rdata_d = ctrl_word;
      end else if (addr_hit(araddr, rpmc_pkg::STAT_ADDR)) begin
        rdata_d = stat_word;
      end else begin
        rdata_d = 32'h0000_0000;
        rresp_d = rpmc_pkg::RESP_SLVERR;
      end
    end
    // Peripheral reset returns LCD control to its initial state
    if (per_rst_q) begin
      lcd_en_d = 1'b0;
      lcd_lvl_d = rpmc_pkg::LCD_LVL_RESET;
    end
    // Core reset covers every source but software; peripherals see all five
    core_rst_d = (mode_q == rpmc_pkg::RPMC_RESET) || sys_rst_req;
    per_rst_d = core_rst_d || srst_q;
    quick_d = (mode_d == rpmc_pkg::RPMC_QUICK);
    reg_start_d = ~osc_ok_d;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= rpmc_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= rpmc_pkg::RESP_OKAY;
      lcd_en_q <= 1'b0;
      lcd_lvl_q <= rpmc_pkg::LCD_LVL_RESET;
      srst_q <= 1'b0;
      core_rst_q <= 1'b1;
      per_rst_q <= 1'b1;
      quick_q <= 1'b0;
      reg_start_q <= 1'b1;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      lcd_en_q <= lcd_en_d;
      lcd_lvl_q <= lcd_lvl_d;
      srst_q <= srst_d;
      core_rst_q <= core_rst_d;
      per_rst_q <= per_rst_d;
      quick_q <= quick_d;
      reg_start_q <= reg_start_d;
    end
  end
  // Ready flags block a second item until the pending write or read response completes
  logic awready_q, wready_q, arready_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
    end else begin
      awready_q <= ~aw_held_d & ~bvalid_d;
      wready_q <= ~w_held_d & ~bvalid_d;
      arready_q <= ~rvalid_d;
    end
  end
  assign awready = awready_q;
  assign wready = wready_q;
  assign arready = arready_q; // Flop is already low while rvalid stands
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign core_reset = core_rst_q;
  assign periph_reset = per_rst_q;
  assign quick_mode = quick_q;
  assign osc_reg_startup = reg_start_q;
  assign lcd_supply_en = lcd_en_q;
  assign lcd_level = lcd_lvl_q;
endmodule
`default_nettype wire

// file: verif/rpmc_checker.sv
// Port-level assertions for the reset and power mode controller
`timescale 1ns/1ps
`default_nettype none
module rpmc_checker #(
  parameter logic [3:0] KEY_SELECT = 4'hf
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic reset_pin,
  input wire logic [3:0] key_inputs,
  input wire logic low_speed_oscillator,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic core_reset,
  input wire logic periph_reset,
  input wire logic osc_reg_startup
);
  logic osc_q, osc_d, tick, keys_on;
  logic [11:0] idle_q, idle_d;
  logic [7:0] pin_q, pin_d, key_q, key_d;
  // Crystal idle time, ticks while pin or key combination is held
  always_comb begin
    tick = low_speed_oscillator && !osc_q;
    keys_on = KEY_SELECT != 4'h0 && (key_inputs & KEY_SELECT) == KEY_SELECT;
    osc_d = low_speed_oscillator;
    idle_d = (low_speed_oscillator != osc_q) ? 12'h000 : idle_q + {11'h000, !(&idle_q)};
    pin_d = !reset_pin ? 8'h00 : pin_q + {7'h00, tick && !(&pin_q)};
    key_d = !keys_on ? 8'h00 : key_q + {7'h00, tick && !(&key_q)};
  end
  // Cleared by bus reset, as the filters are
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_q <= 1'b0;
      idle_q <= 12'h000;
      pin_q <= 8'h00;
      key_q <= 8'h00;
    end else begin
      osc_q <= osc_d;
      idle_q <= idle_d;
      pin_q <= pin_d;
      key_q <= key_d;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_taken;
    arvalid && arready;
  endsequence
  // Margins of a few ticks cover the tick detector lag
  property p_osc_lost;
    idle_q >= 12'ha28 |-> osc_reg_startup && core_reset;
  endproperty
  a_osc_lost: assert property (p_osc_lost) else $error("crystal lost, no reset");
  property p_pin_accept;
    pin_q == 8'h31 |-> ##[0:6] core_reset;
  endproperty
  a_pin_accept: assert property (p_pin_accept) else $error("long pin high, no reset");
  property p_key_accept;
    key_q == 8'h32 |-> ##[0:6] core_reset;
  endproperty
  a_key_accept: assert property (p_key_accept) else $error("long key hold, no reset");
  property p_core_periph;
    $rose(core_reset) |-> ##[0:2] periph_reset;
  endproperty
  a_core_periph: assert property (p_core_periph) else $error("core reset left peripherals");
  property p_wr_resp;
    s_wr_taken |-> ##[1:3] bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
  property p_rd_resp;
    s_rd_taken |=> rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read data late");
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_b_block;
    bvalid |-> !awready && !wready;
  endproperty
  a_b_block: assert property (p_b_block) else $error("write taken during response");
  property p_ar_block;
    rvalid |-> !arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken during response");
endmodule
bind rpmc_top rpmc_checker #(.KEY_SELECT(KEY_SELECT)) rpmc_checker_i (.*);
`default_nettype wire

// file: verif/rpmc_far_side.sv
// Board model: crystal, reset switch, keys and cell comparator
`timescale 1ns/1ps
`default_nettype none
module rpmc_far_side #(
  parameter int HALF = 10
) (
  input wire logic aclk,
  output logic reset_pin,
  output logic [3:0] key_inputs,
  output logic low_speed_oscillator,
  output logic cell_at_1v0
);
  logic run;
  int ph = 0;
  // Pin high from power-on until released after start-up
  initial begin
    reset_pin = 1'b1;
    key_inputs = 4'h0;
    low_speed_oscillator = 1'b0;
    cell_at_1v0 = 1'b0;
    run = 1'b0;
  end
  // Fast crystal keeps the run short; stopped crystal stands low
  always @(posedge aclk) begin
    ph <= (ph == HALF - 1) ? 0 : ph + 1;
    if (!run)
      low_speed_oscillator <= 1'b0;
    else if (ph == HALF - 1)
      low_speed_oscillator <= !low_speed_oscillator;
  end
  task automatic ticks(input int n);
    repeat (n) @(posedge low_speed_oscillator);
    @(posedge aclk);
  endtask
  task automatic pin_pulse(input int n);
    @(posedge aclk);
    reset_pin <= 1'b1;
    ticks(n);
    reset_pin <= 1'b0;
  endtask
  task automatic key_hold(input logic [3:0] v, input int n);
    @(posedge aclk);
    key_inputs <= v;
    ticks(n);
    key_inputs <= 4'h0;
  endtask
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the reset and power mode controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [31:0] CTRL = 32'(rpmc_pkg::CTRL_ADDR);
  localparam logic [31:0] STAT = 32'(rpmc_pkg::STAT_ADDR);
  localparam logic [1:0] OK = rpmc_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = rpmc_pkg::RESP_SLVERR;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, core_reset, periph_reset;
  logic quick_mode, osc_reg_startup, lcd_supply_en, reset_pin, low_speed_oscillator, cell_at_1v0;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] key_inputs, lcd_level, lv, wstrb;
  logic [2:0] awprot, arprot;
  logic lane0;
  logic [1:0] bresp, rresp;
  logic [33:0] expq[$];
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  int hi = 0;
  int ph = 0;
  int h, p;
  int seed = 32'hbededf5d;
  rpmc_top #(.KEY_HOLD_TICKS(8), .CYCLIC_TICKS(64), .SAMPLE_TICKS(4)) rpmc_top_i (.*);
  rpmc_far_side rpmc_far_side_i (.*);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic final_report();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic compare(input string w, input logic [33:0] e, input logic [33:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic lvl(input string w, input logic [2:0] e);
    compare(w, {31'h0, e}, {31'h0, core_reset, osc_reg_startup, quick_mode});
  endtask
  // Ceiling, reset-high cycles, peripheral-only reset cycles
  always @(posedge aclk) begin
    cyc++;
    hi += (core_reset === 1'b1);
    ph += (periph_reset === 1'b1 && core_reset === 1'b0);
    if (cyc == 40000) begin
      fails++;
      final_report();
    end
  end
  // Bus answers matched to the oldest note
  always @(posedge aclk) begin
    if (bvalid === 1'b1 && bready === 1'b1)
      compare("write response", expq.pop_front(), {bresp, 32'h0000_0000});
    if (rvalid === 1'b1 && rready === 1'b1)
      compare("read data", expq.pop_front(), {rresp, rdata});
  end
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    expq.push_back({r, 32'h0000_0000});
    awaddr <= a;
    wdata <= d;
    awprot <= 3'($random(seed));
    wstrb <= {3'($random(seed)), lane0};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (awvalid && !awready || wvalid && !wready);
    repeat ($unsigned($random(seed)) % 3) @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    expq.push_back(e);
    araddr <= a;
    arprot <= 3'($random(seed));
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    repeat ($unsigned($random(seed)) % 3) @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 32'h0000_0000;
    wdata = 32'h0000_0000;
    araddr = 32'h0000_0000;
    awprot = 3'h0;
    arprot = 3'h0;
    wstrb = 4'hf;
    lane0 = 1'b1;
    repeat (2) @(posedge aclk);
    lvl("reset state", 3'h6);
    aresetn <= 1'b1;
    rpmc_far_side_i.run <= 1'b1;
    rpmc_far_side_i.ticks(48);
    lvl("pin held", 3'h4);
    rpmc_far_side_i.pin_pulse(1);
    repeat (8) @(posedge aclk);
    lvl("quick start", 3'h1);
    rd(STAT, {OK, 32'h0000_0005});
    $display("test start-up done");
    h = hi;
    rpmc_far_side_i.pin_pulse(13);
    rpmc_far_side_i.ticks(4);
    compare("short pin", 34'h0, 34'(hi - h));
    rpmc_far_side_i.pin_pulse(49);
    compare("long pin", 34'h1, {33'h0, hi > h});
    repeat (8) @(posedge aclk);
    lvl("pin released", 3'h1);
    h = hi;
    rpmc_far_side_i.ticks(70);
    compare("cyclic reset", 34'h1, {33'h0, (hi - h) inside {[10:40]}});
    $display("test pin and cyclic done");
    rpmc_far_side_i.cell_at_1v0 <= 1'b1;
    rpmc_far_side_i.ticks(10);
    lvl("normal mode", 3'h0);
    rd(STAT, {OK, 32'h0000_0006});
    h = hi;
    rpmc_far_side_i.ticks(70);
    compare("no cyclic", 34'h0, 34'(hi - h));
    for (int i = 0; i < 4; i++)
      rpmc_far_side_i.key_hold(4'hf ^ (4'h1 << i), 50);
    rpmc_far_side_i.key_hold(4'hf, 33);
    compare("partial keys", 34'h0, 34'(hi - h));
    rpmc_far_side_i.key_hold(4'hf, 50);
    compare("key reset", 34'h1, {33'h0, hi > h});
    rpmc_far_side_i.ticks(10);
    $display("test keys done");
    lvl("regs out of quick", 3'h0);
    for (int i = 0; i < 16; i++) begin
      lv = 4'(i);
      p = $random(seed) & 2;
      wr(CTRL, 32'(lv) << 4 | 32'(p), OK);
      rd(CTRL, {OK, 24'h00_0000, lv, 4'(p)});
      compare("lcd", {29'h0, lv, p[1]}, {29'h0, lcd_level, lcd_supply_en});
    end
    h = hi;
    p = ph;
    wr(CTRL, 32'h0000_00f3, OK);
    repeat (4) @(posedge aclk);
    compare("soft core", 34'h0, 34'(hi - h));
    compare("soft periph", 34'h1, {33'h0, ph > p});
    rd(CTRL, {OK, 32'h0000_0000});
    p = ph;
    wr(CTRL, 32'h0000_0000, OK);
    compare("zero write", 34'h0, 34'(ph - p));
    lane0 = 1'b0;
    wr(CTRL, 32'h0000_0052, OK);
    rd(CTRL, {OK, 32'h0000_0000});
    lane0 = 1'b1;
    wr(32'h0000_0008, 32'h0000_00f2, ERR);
    rd(32'h0000_000c, {ERR, 32'h0000_0000});
    wr(STAT, 32'h0000_001f, OK);
    rd(STAT, {OK, 32'h0000_0006});
    $display("test registers done");
    rpmc_far_side_i.run <= 1'b0;
    repeat (2700) @(posedge aclk);
    lvl("crystal stopped", 3'h6);
    rpmc_far_side_i.run <= 1'b1;
    rpmc_far_side_i.ticks(10);
    lvl("crystal back", 3'h0);
    $display("test crystal done");
    final_report();
  end
endmodule
`default_nettype wire
